//--- rpcg_pkg.sv
`default_nettype none
package rpcg_pkg;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam logic [11:0] RPCG_SYSCTL_BASE_HI = 12'h400;
    localparam logic [7:0] RPCG_SYSCTL_BASE_MID = 8'hFE;
    localparam logic [11:0] RPCG_OFF_RUN_GATE = 12'h104;
    localparam logic [11:0] RPCG_OFF_SLEEP_GATE = 12'h114;
    localparam logic [11:0] RPCG_OFF_DEEP_GATE = 12'h124;
    localparam logic [11:0] RPCG_OFF_INT_STATUS = 12'h130;
    localparam logic [11:0] RPCG_OFF_INT_MASK = 12'h134;
    localparam logic [11:0] RPCG_OFF_GATE_STATE = 12'h138;

    // ********************************************************
    // Field positions of the gating registers
    // ********************************************************
    localparam int RPCG_BIT_UART_ZERO = 0;
    localparam int RPCG_BIT_UART_ONE = 1;
    localparam int RPCG_BIT_UART_TWO = 2;
    localparam int RPCG_BIT_SYNC_ZERO = 4;
    localparam int RPCG_BIT_SYNC_ONE = 5;
    localparam int RPCG_BIT_QDEC_ZERO = 8;
    localparam int RPCG_BIT_QDEC_ONE = 9;
    localparam int RPCG_BIT_TWI_ZERO = 12;
    localparam int RPCG_BIT_TWI_ONE = 14;
    localparam int RPCG_BIT_TMR_ZERO = 16;
    localparam int RPCG_BIT_TMR_THREE = 19;

    // Writable bits; all others read zero
    localparam logic [31:0] RPCG_GATE_MASK = 32'h000F5337;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [31:0] RPCG_RUN_RESET = 32'h00000000;
    localparam logic [31:0] RPCG_SLEEP_RESET = 32'h00000000;
    localparam logic [31:0] RPCG_DEEP_RESET = 32'h00000000;
    localparam logic [31:0] RPCG_INT_RESET = 32'h00000000;

    // ********************************************************
    // Power states
    // ********************************************************
    typedef enum logic [2:0] {
        RPCG_PS_RUN = 3'b001,
        RPCG_PS_SLEEP = 3'b010,
        RPCG_PS_DEEP = 3'b100
    } rpcg_pstate_t;

endpackage : rpcg_pkg
`default_nettype wire

//--- rpcg_top.sv
`timescale 1ns/1ps
`default_nettype none

module rpcg_top
    import rpcg_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 32
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic cpu_sleep,
    input wire logic cpu_deep_sleep,
    input wire logic auto_clock_gating_enable,
    input wire logic [31:0] unit_access,
    output logic unit_bus_fault,
    output logic [31:0] unit_clk_en,
    output logic [31:0] unit_clk,
    output logic irq
);

    // ********************************************************
    // Decode helpers
    // ********************************************************

    // Matches a register offset inside the system control space
    function automatic logic rpcg_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [11:0] off);
        rpcg_hit = (addr[ADDR_W-1:20] == (ADDR_W-20)'(RPCG_SYSCTL_BASE_HI))
            && (addr[19:12] == RPCG_SYSCTL_BASE_MID) && (addr[11:0] == off);
    endfunction : rpcg_hit

    // Keeps only implemented gating bits
    function automatic logic [31:0] rpcg_clean(input logic [31:0] val);
        rpcg_clean = val & RPCG_GATE_MASK;
    endfunction : rpcg_clean

    // ********************************************************
    // Signals
    // ********************************************************
    logic [31:0] run_gate_reg_1_r;
    logic [31:0] sleep_gate_reg_1_r;
    logic [31:0] deep_sleep_gate_reg_1_r;
    logic [31:0] int_status_r;
    logic [31:0] int_mask_r;
    logic [31:0] eff_gate_r;
    logic [31:0] eff_gate_nxt;
    logic [31:0] fault_vec;
    logic [31:0] w1c_clear;
    logic [DATA_W-1:0] rdata_nxt;
    rpcg_pstate_t pstate_r;
    rpcg_pstate_t pstate_nxt;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_stat;
    logic wr_mask;

    // ********************************************************
    // Write decode
    // ********************************************************

    // One strobe per writable register
    assign wr_run = reg_wr && rpcg_hit(reg_addr, RPCG_OFF_RUN_GATE);
    assign wr_sleep = reg_wr && rpcg_hit(reg_addr, RPCG_OFF_SLEEP_GATE);
    assign wr_deep = reg_wr && rpcg_hit(reg_addr, RPCG_OFF_DEEP_GATE);
    assign wr_stat = reg_wr && rpcg_hit(reg_addr, RPCG_OFF_INT_STATUS);
    assign wr_mask = reg_wr && rpcg_hit(reg_addr, RPCG_OFF_INT_MASK);

    // ********************************************************
    // Gating registers
    // ********************************************************

    // Run-mode gating; reserved bits never stored
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_gate_reg_1_r <= RPCG_RUN_RESET;
        end else if (wr_run) begin
            run_gate_reg_1_r <= rpcg_clean(reg_wdata[31:0]);
        end
    end

    // Sleep-mode gating, same layout
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sleep_gate_reg_1_r <= RPCG_SLEEP_RESET;
        end else if (wr_sleep) begin
            sleep_gate_reg_1_r <= rpcg_clean(reg_wdata[31:0]);
        end
    end

    // Deep-sleep gating, same layout
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            deep_sleep_gate_reg_1_r <= RPCG_DEEP_RESET;
        end else if (wr_deep) begin
            deep_sleep_gate_reg_1_r <= rpcg_clean(reg_wdata[31:0]);
        end
    end

    // ********************************************************
    // Power state tracking
    // ********************************************************

    // Deep sleep outranks sleep
    always_comb begin
        if (cpu_deep_sleep) begin
            pstate_nxt = RPCG_PS_DEEP;
        end else if (cpu_sleep) begin
            pstate_nxt = RPCG_PS_SLEEP;
        end else begin
            pstate_nxt = RPCG_PS_RUN;
        end
    end

    // Registered power state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pstate_r <= RPCG_PS_RUN;
        end else begin
            pstate_r <= pstate_nxt;
        end
    end

    // Pick the gating set for the present state, or the run set when auto_clock_gating_enable is low
    always_comb begin
        case (pstate_r)
            RPCG_PS_RUN: begin
                eff_gate_nxt = run_gate_reg_1_r;
            end
            RPCG_PS_SLEEP: begin
                if (auto_clock_gating_enable) begin
                    eff_gate_nxt = sleep_gate_reg_1_r;
                end else begin
                    eff_gate_nxt = run_gate_reg_1_r;
                end
            end
            RPCG_PS_DEEP: begin
                if (auto_clock_gating_enable) begin
                    eff_gate_nxt = deep_sleep_gate_reg_1_r;
                end else begin
                    eff_gate_nxt = run_gate_reg_1_r;
                end
            end
            default: begin
                eff_gate_nxt = run_gate_reg_1_r;
            end
        endcase
    end

    // Effective enables, one cycle after the source changes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            eff_gate_r <= RPCG_RUN_RESET;
        end else begin
            eff_gate_r <= rpcg_clean(eff_gate_nxt);
        end
    end

    // Enable levels seen by the units
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unit_clk_en <= RPCG_RUN_RESET;
        end else begin
            unit_clk_en <= rpcg_clean(eff_gate_nxt);
        end
    end

    // ********************************************************
    // Glitch-free clock gates
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_gate
            if (RPCG_GATE_MASK[gi]) begin : g_impl
                logic en_lat;
                // Transparent while the clock is low, so no runt pulses
                always_latch begin
                    if (!mclk) begin
                        en_lat = eff_gate_r[gi];
                    end
                end
                assign unit_clk[gi] = mclk & en_lat;
            end else begin : g_none
                assign unit_clk[gi] = 1'b0;
            end
        end
    endgenerate

    // ********************************************************
    // Bus fault on access to a gated unit
    // ********************************************************

    // Accesses whose unit has no clock
    assign fault_vec = unit_access & ~eff_gate_r & RPCG_GATE_MASK;

    // Fault answered in the cycle after the access
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unit_bus_fault <= 1'b0;
        end else begin
            unit_bus_fault <= |fault_vec;
        end
    end

    // ********************************************************
    // Interrupt status and mask
    // ********************************************************

    // Write-one-to-clear
    assign w1c_clear = wr_stat ? reg_wdata[31:0] : 32'h00000000;

    // New faults win over a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            int_status_r <= RPCG_INT_RESET;
        end else begin
            int_status_r <= (int_status_r & ~w1c_clear) | fault_vec;
        end
    end

    // Mask register, same layout
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            int_mask_r <= RPCG_INT_RESET;
        end else if (wr_mask) begin
            int_mask_r <= rpcg_clean(reg_wdata[31:0]);
        end
    end

    // Level interrupt
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_status_r & ~w1c_clear) | fault_vec) & int_mask_r);
        end
    end

    // ********************************************************
    // Read path
    // ********************************************************

    // Read mux; unmapped reads return zero
    always_comb begin
        rdata_nxt = '0;
        if (rpcg_hit(reg_addr, RPCG_OFF_RUN_GATE)) begin
            rdata_nxt[31:0] = run_gate_reg_1_r;
        end else if (rpcg_hit(reg_addr, RPCG_OFF_SLEEP_GATE)) begin
            rdata_nxt[31:0] = sleep_gate_reg_1_r;
        end else if (rpcg_hit(reg_addr, RPCG_OFF_DEEP_GATE)) begin
            rdata_nxt[31:0] = deep_sleep_gate_reg_1_r;
        end else if (rpcg_hit(reg_addr, RPCG_OFF_INT_STATUS)) begin
            rdata_nxt[31:0] = int_status_r;
        end else if (rpcg_hit(reg_addr, RPCG_OFF_INT_MASK)) begin
            rdata_nxt[31:0] = int_mask_r;
        end else if (rpcg_hit(reg_addr, RPCG_OFF_GATE_STATE)) begin
            rdata_nxt[31:0] = eff_gate_r;
        end
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : rpcg_top
`default_nettype wire

//--- rpcg_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the clock gate block
// ****************************************
module rpcg_props
    import rpcg_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 32
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic cpu_sleep,
    input wire logic cpu_deep_sleep,
    input wire logic auto_clock_gating_enable,
    input wire logic [31:0] unit_access,
    input wire logic unit_bus_fault,
    input wire logic [31:0] unit_clk_en,
    input wire logic [31:0] unit_clk,
    input wire logic irq
);
    localparam logic [31:0] RUN_A = {RPCG_SYSCTL_BASE_HI, RPCG_SYSCTL_BASE_MID, RPCG_OFF_RUN_GATE};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Run register write while running, and a read of it
    sequence s_run_wr;
        reg_wr && reg_addr == RUN_A && !cpu_sleep && !cpu_deep_sleep;
    endsequence
    sequence s_run_rd;
        reg_rd && reg_addr == RUN_A;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not idle");
    a_wr_readback: assert property (s_run_wr ##1 s_run_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & RPCG_GATE_MASK)) else $error("bad readback");
    a_run_apply: assert property (s_run_wr ##1 (!cpu_sleep && !cpu_deep_sleep && !reg_wr) |=>
        unit_clk_en == ($past(reg_wdata, 2) & RPCG_GATE_MASK))
        else $error("run gate not applied");
    a_fault_set: assert property ((|(unit_access & ~unit_clk_en)) |=> unit_bus_fault)
        else $error("missing bus fault");
    a_fault_none: assert property (!(|(unit_access & ~unit_clk_en)) |=> !unit_bus_fault)
        else $error("spurious bus fault");
    a_clk_low: assert property (unit_clk == 32'h00000000)
        else $error("gated clock high in low phase");
    a_clk_follow: assert property (@(negedge mclk) unit_clk == $past(unit_clk_en))
        else $error("gated clock wrong");
    a_irq_cause: assert property ($rose(irq) |-> unit_bus_fault || $past(reg_wr, 2))
        else $error("interrupt without cause");
    a_reset_clear: assert property ($rose(resetn) |-> unit_clk_en == 32'h00000000 && !irq)
        else $error("state not cleared");
endmodule : rpcg_props
bind rpcg_top rpcg_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) rpcg_props_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep),
    .cpu_deep_sleep(cpu_deep_sleep), .auto_clock_gating_enable(auto_clock_gating_enable),
    .unit_access(unit_access), .unit_bus_fault(unit_bus_fault), .unit_clk_en(unit_clk_en),
    .unit_clk(unit_clk), .irq(irq));
`default_nettype wire

//--- rpcg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rpcg_top_tb
    import rpcg_pkg::*;
;
    // Timers, I2C, decoders, serial ports, UARTs
    localparam logic [31:0] UNITS = 32'h000F0000 | 32'h00005000 | 32'h00000300 | 32'h00000037;
    logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic cpu_sleep = 1'b0, cpu_deep_sleep = 1'b0, auto_clock_gating_enable = 1'b0;
    logic [31:0] reg_addr = 32'h00000000, reg_wdata = 32'h00000000, unit_access = 32'h00000000;
    logic [31:0] reg_rdata, unit_clk_en, unit_clk;
    logic unit_bus_fault, irq;
    int fails = 0;
    int samples_checked = 0;
    // ****************************************
    // Clock and design
    // ****************************************
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    rpcg_top rpcg_top_inst (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_sleep(cpu_sleep), .cpu_deep_sleep(cpu_deep_sleep),
        .auto_clock_gating_enable(auto_clock_gating_enable), .unit_access(unit_access),
        .unit_bus_fault(unit_bus_fault), .unit_clk_en(unit_clk_en), .unit_clk(unit_clk),
        .irq(irq));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic conclude();
        if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // One bus cycle, launched just after a rising edge
    task automatic bus(input logic w, input logic r, input logic [11:0] off, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= {RPCG_SYSCTL_BASE_HI, RPCG_SYSCTL_BASE_MID, off};
        reg_wdata <= d;
    endtask : bus
    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        bus(1'b1, 1'b0, off, d);
        bus(1'b0, 1'b0, off, 32'h00000000);
    endtask : wr
    task automatic rd(input logic [11:0] off, input logic [31:0] exp);
        bus(1'b0, 1'b1, off, 32'h00000000);
        bus(1'b0, 1'b0, off, 32'h00000000);
        #1 chk("rdata", exp, reg_rdata);
    endtask : rd
    // Access a unit; fault and interrupt show one cycle later
    task automatic acc(input logic [31:0] m, input logic f, input logic q);
        @(posedge mclk);
        unit_access <= m;
        @(posedge mclk);
        unit_access <= 32'h00000000;
        #1 chk("fault", {31'h0, f}, {31'h0, unit_bus_fault});
        chk("irq", {31'h0, q}, {31'h0, irq});
    endtask : acc
    // Power state change, then effective gate check
    task automatic pst(input logic s, input logic dp, input logic ag, input logic [31:0] exp);
        @(posedge mclk);
        cpu_sleep <= s;
        cpu_deep_sleep <= dp;
        auto_clock_gating_enable <= ag;
        repeat (3) @(posedge mclk);
        #1 chk("clk_en", exp, unit_clk_en);
        rd(RPCG_OFF_GATE_STATE, exp);
    endtask : pst
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        rd(RPCG_OFF_RUN_GATE, 32'h00000000);
        rd(RPCG_OFF_SLEEP_GATE, 32'h00000000);
        rd(RPCG_OFF_DEEP_GATE, 32'h00000000);
        chk("clk_en", 32'h00000000, unit_clk_en);
        for (int i = 0; i < 32; i++) begin
            wr(RPCG_OFF_RUN_GATE, 32'h00000001 << i);
            repeat (2) @(posedge mclk);
            #1 chk("clk_en", (32'h00000001 << i) & UNITS, unit_clk_en);
            rd(RPCG_OFF_RUN_GATE, (32'h00000001 << i) & UNITS);
        end
        bus(1'b1, 1'b0, RPCG_OFF_RUN_GATE, 32'hFFFFFFFF);
        rd(RPCG_OFF_RUN_GATE, UNITS);
        wr(12'h100, 32'hFFFFFFFF);
        rd(12'h100, 32'h00000000);
        wr(RPCG_OFF_RUN_GATE, 32'h00000001);
        wr(RPCG_OFF_INT_MASK, 32'hFFFFFFFF);
        acc(32'h00000001, 1'b0, 1'b0);
        acc(32'h00080000, 1'b1, 1'b1);
        rd(RPCG_OFF_INT_STATUS, 32'h00080000);
        wr(RPCG_OFF_INT_STATUS, 32'h00080000);
        #1 chk("irq", 32'h00000000, {31'h0, irq});
        wr(RPCG_OFF_INT_MASK, 32'h00000000);
        acc(32'h00000002, 1'b1, 1'b0);
        wr(RPCG_OFF_INT_MASK, 32'h00000002);
        @(posedge mclk);
        #1 chk("irq", 32'h00000001, {31'h0, irq});
        wr(RPCG_OFF_INT_STATUS, 32'h00000002);
        rd(RPCG_OFF_INT_STATUS, 32'h00000000);
        wr(RPCG_OFF_SLEEP_GATE, 32'h00000010);
        wr(RPCG_OFF_DEEP_GATE, 32'h00000100);
        pst(1'b1, 1'b0, 1'b0, 32'h00000001);
        pst(1'b1, 1'b0, 1'b1, 32'h00000010);
        acc(32'h00000001, 1'b1, 1'b0);
        pst(1'b0, 1'b1, 1'b1, 32'h00000100);
        pst(1'b1, 1'b1, 1'b1, 32'h00000100);
        pst(1'b0, 1'b1, 1'b0, 32'h00000001);
        pst(1'b0, 1'b0, 1'b1, 32'h00000001);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk("clk_en", 32'h00000000, unit_clk_en);
        rd(RPCG_OFF_RUN_GATE, 32'h00000000);
        conclude();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule : rpcg_top_tb
`default_nettype wire
